/* verilog/bsdvs_top.sv */
// Purpose: short latch/shutdown, power-good, thermal gating and dvs voltage select
// Assumes: status inputs are synchronous to mclk_in; pins are asynchronous
// Notes:   one-cycle wait then answer on every register access
// Operation
// - sink current limit enable, reset enabled
// - route selected monitor to adc channel four
// - thermal flags only while monitoring enabled
// - overcurrent sets short flag, maskable interrupt
// - latched short holds rail off
// - short flags clear on read or reset
// - same behaviour for linear regulator shorts
// - shutdown only after continuous qualification time
// - startup counter masks shutdown for 2 ms
// - common power-good type select
// - power-good needs voltage and current ok
// - per-source mask, only rail one unmasked
// - ramping suppresses voltage check
// - include adc current result when enabled
// - dual phase forces mask bit one
// - dvs rails ramp at fixed slew
// - pin active selects primary else alternate
// - command bit selects setting without pins
// - alternate code zero turns rail off
// - strap picks dual phase, force field
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module bsdvs_top #(
	parameter int STARTUP_CYCLES = bsdvs_pkg::STARTUP_CYCLES
) (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// avalon-mm slave
	input  wire logic [7:0]  address_in,
	input  wire logic        read_in,
	input  wire logic        write_in,
	input  wire logic [31:0] writedata_in,
	input  wire logic [3:0]  byteenable_in,
	output logic      [31:0] readdata_out,
	output logic             waitrequest_out,
	output logic      [1:0]  response_out,
	// rail status from analog
	input  wire logic        device_enable_in,
	input  wire logic [9:0]  rail_enable_in,
	input  wire logic [9:0]  overcurrent_in,
	input  wire logic [4:0]  voltage_ok_in,
	input  wire logic [4:0]  load_current_ok_in,
	input  wire logic        adc_current_ok_in,
	input  wire logic [2:0]  thermal_sensor_in,
	input  wire logic [4:0]  pwm_mode_in,
	input  wire logic        light_load_in,
	input  wire logic        otp_dual_phase_in,
	// control pins
	input  wire logic        sleep_request_pin_in,
	input  wire logic        rail_control_pin_a_in,
	input  wire logic        rail_control_pin_b_in,
	// control outputs
	output logic             sink_limit_enable_out,
	output logic      [2:0]  load_current_monitor_select_out,
	output logic             adc_ch4_valid_out,
	output logic      [2:0]  buck_thermal_flags_out,
	output logic             short_irq_out,
	output logic      [4:0]  buck_off_out,
	output logic      [4:0]  linear_off_out,
	output logic             power_good_out,
	output logic      [39:0] voltage_code_out,
	output logic             dual_phase_out,
	output logic             two_phase_active_out
);
	localparam int QUAL_LAST = bsdvs_pkg::QUAL_CYCLES - 1;
	localparam int STEP_LAST = bsdvs_pkg::STEP_CYCLES - 1;

	bsdvs_pkg::bsdvs_bus_state_t bus_state_reg;
	bsdvs_pkg::bsdvs_rail_cfg_t  rail_cfg_reg [bsdvs_pkg::NUM_BUCK];
	logic [9:0]  ctrl_reg;
	logic [4:0]  mask_a_reg;
	logic        mask_b_reg;
	logic [4:0]  buck_flag_reg;
	logic [4:0]  linear_flag_reg;
	logic [9:0]  short_set;
	logic [11:0] qual_cnt_reg [10];
	logic [15:0] start_cnt_reg;
	logic        startup_masked_reg;
	logic [9:0]  rail_en_prev_reg;
	logic [2:0]  pin_ff1_reg;
	logic [2:0]  pin_ff2_reg;
	logic [2:0]  pin_ff3_reg;
	logic [2:0]  pin_state_reg;
	logic        strap_done_reg;
	logic        dual_reg;
	logic [7:0]  cur_code_reg [bsdvs_pkg::NUM_BUCK];
	logic [6:0]  step_cnt_reg [bsdvs_pkg::NUM_DVS];
	logic [7:0]  target_code [bsdvs_pkg::NUM_BUCK];
	logic [4:0]  alt_off;
	logic [4:0]  ramping;
	logic [31:0] rd_value;
	logic        rd_hit;
	logic        req;
	logic        accept;
	logic [2:0]  rail_idx;
	logic        rail_hit;
	logic [31:0] rd_snap_reg;
	logic [7:0]  addr_snap_reg;
	logic [31:0] rail_word;
	logic [4:0]  eff_mask;
	logic [4:0]  src_ok;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] m;
		m = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				m[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return m;
	endfunction : be_merge

	function automatic logic mon_in_pwm(input logic [2:0] sel, input logic [4:0] pwm);
		case (sel)
			bsdvs_pkg::MON_B1, bsdvs_pkg::MON_B12: mon_in_pwm = pwm[0];
			bsdvs_pkg::MON_B2: mon_in_pwm = pwm[1];
			bsdvs_pkg::MON_B3: mon_in_pwm = pwm[2];
			bsdvs_pkg::MON_B5: mon_in_pwm = pwm[4];
			default: mon_in_pwm = 1'b0;
		endcase
	endfunction : mon_in_pwm

	assign req      = read_in | write_in;
	assign accept   = req & (bus_state_reg == bsdvs_pkg::BUS_ANSWER);
	assign rail_idx = 3'((address_in - bsdvs_pkg::OFS_RAIL_BASE) >> 2);
	assign rail_hit = (address_in >= bsdvs_pkg::OFS_RAIL_BASE) &&
		(address_in <= bsdvs_pkg::OFS_RAIL_LAST) && (address_in[1:0] == 2'h0);
	assign rail_word = rail_hit ? {cur_code_reg[rail_idx], 3'h0, rail_cfg_reg[rail_idx]} : 32'h0;

	// bus handshake: one wait cycle, answer on the second
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			bus_state_reg   <= bsdvs_pkg::BUS_IDLE;
			waitrequest_out <= 1'b1;
			readdata_out    <= 32'h0;
			response_out    <= bsdvs_pkg::RESP_OKAY;
			rd_snap_reg     <= 32'h0;
			addr_snap_reg   <= 8'h00;
		end
		else
		begin
			case (bus_state_reg)
				bsdvs_pkg::BUS_IDLE:
				begin
					if (req)
					begin
						bus_state_reg   <= bsdvs_pkg::BUS_ANSWER;
						waitrequest_out <= 1'b0;
						readdata_out    <= read_in ? rd_value : 32'h0;
						rd_snap_reg     <= read_in ? rd_value : 32'h0;
						addr_snap_reg   <= address_in;
						response_out    <= rd_hit ? bsdvs_pkg::RESP_OKAY : bsdvs_pkg::RESP_SLVERR;
					end
				end
				bsdvs_pkg::BUS_ANSWER:
				begin
					bus_state_reg   <= bsdvs_pkg::BUS_IDLE;
					waitrequest_out <= 1'b1;
				end
				default:
				begin
					bus_state_reg   <= bsdvs_pkg::BUS_IDLE;
					waitrequest_out <= 1'b1;
				end
			endcase
		end
	end

	always_comb
	begin
		rd_value = 32'h0;
		rd_hit   = 1'b1;
		case (address_in)
			bsdvs_pkg::OFS_CTRL:         rd_value = {22'h0, ctrl_reg};
			bsdvs_pkg::OFS_MASK_A:       rd_value = {27'h0, mask_a_reg};
			bsdvs_pkg::OFS_MASK_B:       rd_value = {31'h0, mask_b_reg};
			bsdvs_pkg::OFS_STATUS:       rd_value = {21'h0, startup_masked_reg, dual_reg,
				power_good_out, 5'h0, buck_thermal_flags_out};
			bsdvs_pkg::OFS_BUCK_SHORT:   rd_value = {27'h0, buck_flag_reg};
			bsdvs_pkg::OFS_LINEAR_SHORT: rd_value = {27'h0, linear_flag_reg};
			default:
			begin
				rd_value = rail_word;
				rd_hit   = rail_hit;
			end
		endcase
	end

	// software writable configuration
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ctrl_reg   <= bsdvs_pkg::CTRL_RESET;
			mask_a_reg <= bsdvs_pkg::MASK_A_RESET;
			mask_b_reg <= bsdvs_pkg::MASK_B_RESET;
			for (int i = 0; i < bsdvs_pkg::NUM_BUCK; i++)
				rail_cfg_reg[i] <= bsdvs_pkg::RAIL_CFG_RESET;
		end
		else if (accept && write_in)
		begin
			if (address_in == bsdvs_pkg::OFS_CTRL)
				ctrl_reg <= 10'(be_merge({22'h0, ctrl_reg}, writedata_in, byteenable_in));
			if (address_in == bsdvs_pkg::OFS_MASK_A)
				mask_a_reg <= 5'(be_merge({27'h0, mask_a_reg}, writedata_in, byteenable_in));
			if (address_in == bsdvs_pkg::OFS_MASK_B)
				mask_b_reg <= byteenable_in[0] ? writedata_in[0] : mask_b_reg;
			if (rail_hit)
				rail_cfg_reg[rail_idx] <= 21'(be_merge({11'h0, rail_cfg_reg[rail_idx]},
					writedata_in, byteenable_in));
		end
	end

	// pin synchroniser, change taken when stages two and three agree
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_ff1_reg   <= 3'h0;
			pin_ff2_reg   <= 3'h0;
			pin_ff3_reg   <= 3'h0;
			pin_state_reg <= 3'h0;
		end
		else
		begin
			pin_ff1_reg <= {rail_control_pin_b_in, rail_control_pin_a_in, sleep_request_pin_in};
			pin_ff2_reg <= pin_ff1_reg;
			pin_ff3_reg <= pin_ff2_reg;
			for (int p = 0; p < 3; p++)
			begin
				if (pin_ff2_reg[p] == pin_ff3_reg[p])
					pin_state_reg[p] <= pin_ff3_reg[p];
			end
		end
	end

	// phase strap caught after reset release
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			strap_done_reg <= 1'b0;
			dual_reg       <= 1'b0;
		end
		else if (!strap_done_reg)
		begin
			strap_done_reg <= 1'b1;
			dual_reg       <= otp_dual_phase_in;
		end
	end

	// force or shed at light load
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			two_phase_active_out <= 1'b0;
		else if (!dual_reg)
			two_phase_active_out <= 1'b0;
		else if (ctrl_reg[bsdvs_pkg::CTRL_PHASE_LSB +: 2] == bsdvs_pkg::PHASE_FORCE_DUAL)
			two_phase_active_out <= 1'b1;
		else if (ctrl_reg[bsdvs_pkg::CTRL_PHASE_LSB +: 2] == bsdvs_pkg::PHASE_FORCE_SINGLE)
			two_phase_active_out <= 1'b0;
		else
			two_phase_active_out <= ~light_load_in;
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			start_cnt_reg      <= 16'h0000;
			startup_masked_reg <= 1'b1;
			rail_en_prev_reg   <= 10'h000;
		end
		else
		begin
			rail_en_prev_reg <= rail_enable_in;
			if (!device_enable_in || |(rail_enable_in & ~rail_en_prev_reg))
			begin
				start_cnt_reg      <= 16'h0000;
				startup_masked_reg <= 1'b1;
			end
			else if (start_cnt_reg == 16'(STARTUP_CYCLES - 1))
				startup_masked_reg <= 1'b0;
			else
				start_cnt_reg <= start_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int r = 0; r < 10; r++)
				qual_cnt_reg[r] <= 12'h000;
		end
		else
		begin
			for (int r = 0; r < 10; r++)
			begin
				if (!(overcurrent_in[r] && rail_enable_in[r]))
					qual_cnt_reg[r] <= 12'h000;
				else if (qual_cnt_reg[r] != 12'(QUAL_LAST))
					qual_cnt_reg[r] <= qual_cnt_reg[r] + 12'h001;
			end
		end
	end

	always_comb
	begin
		for (int r = 0; r < 10; r++)
			short_set[r] = overcurrent_in[r] && rail_enable_in[r] &&
				(qual_cnt_reg[r] == 12'(QUAL_LAST)) && !startup_masked_reg;
	end

	// clear only the bits read, set wins
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			buck_flag_reg   <= 5'h00;
			linear_flag_reg <= 5'h00;
		end
		else
		begin
			buck_flag_reg <= (buck_flag_reg & ~((accept && read_in &&
				addr_snap_reg == bsdvs_pkg::OFS_BUCK_SHORT) ? rd_snap_reg[4:0] : 5'h00))
				| short_set[4:0];
			linear_flag_reg <= (linear_flag_reg & ~((accept && read_in &&
				addr_snap_reg == bsdvs_pkg::OFS_LINEAR_SHORT) ? rd_snap_reg[4:0] : 5'h00))
				| short_set[9:5];
		end
	end

	// voltage target select
	always_comb
	begin
		for (int i = 0; i < bsdvs_pkg::NUM_BUCK; i++)
		begin
			logic use_alt;
			use_alt = 1'b0;
			if (rail_cfg_reg[i].roof_floor_en)
				use_alt = (rail_cfg_reg[i].pin_map != 3'h0) &&
					!(|(rail_cfg_reg[i].pin_map & pin_state_reg));
			else
				use_alt = rail_cfg_reg[i].cmd;
			target_code[i] = use_alt ? rail_cfg_reg[i].alternate_voltage_setting
				: rail_cfg_reg[i].primary_voltage_setting;
			alt_off[i] = use_alt && (rail_cfg_reg[i].alternate_voltage_setting == 8'h00);
			ramping[i] = (i < bsdvs_pkg::NUM_DVS) && (cur_code_reg[i] != target_code[i]);
		end
	end

	// one code step per slew interval
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < bsdvs_pkg::NUM_BUCK; i++)
				cur_code_reg[i] <= bsdvs_pkg::RAIL_CFG_RESET.primary_voltage_setting;
			for (int i = 0; i < bsdvs_pkg::NUM_DVS; i++)
				step_cnt_reg[i] <= 7'h00;
		end
		else
		begin
			for (int i = 0; i < bsdvs_pkg::NUM_DVS; i++)
			begin
				if (!ramping[i] || step_cnt_reg[i] == 7'(STEP_LAST))
					step_cnt_reg[i] <= 7'h00;
				else
					step_cnt_reg[i] <= step_cnt_reg[i] + 7'h01;
				if (ramping[i] && step_cnt_reg[i] == 7'(STEP_LAST))
					cur_code_reg[i] <= (cur_code_reg[i] < target_code[i]) ?
						cur_code_reg[i] + 8'h01 : cur_code_reg[i] - 8'h01;
			end
			for (int i = bsdvs_pkg::NUM_DVS; i < bsdvs_pkg::NUM_BUCK; i++)
				cur_code_reg[i] <= target_code[i];
		end
	end

	// power-good aggregation
	always_comb
	begin
		eff_mask = mask_a_reg | (dual_reg ? 5'h02 : 5'h00);
		for (int i = 0; i < bsdvs_pkg::NUM_BUCK; i++)
			src_ok[i] = eff_mask[i] || (load_current_ok_in[i] &&
				(mask_b_reg || voltage_ok_in[i] || ramping[i]));
	end

	// outputs and status
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			power_good_out         <= 1'b0;
			buck_thermal_flags_out <= 3'h0;
			short_irq_out          <= 1'b0;
			buck_off_out           <= 5'h00;
			linear_off_out         <= 5'h00;
			adc_ch4_valid_out      <= 1'b0;
		end
		else
		begin
			power_good_out <= (&src_ok) &&
				(!ctrl_reg[bsdvs_pkg::CTRL_CMPINC_BIT] || adc_current_ok_in);
			buck_thermal_flags_out <= ctrl_reg[bsdvs_pkg::CTRL_THERM_BIT] ?
				thermal_sensor_in : 3'h0;
			short_irq_out <= (|buck_flag_reg || |linear_flag_reg) &&
				!ctrl_reg[bsdvs_pkg::CTRL_IRQMASK_BIT];
			buck_off_out   <= buck_flag_reg | alt_off;
			linear_off_out <= linear_flag_reg;
			adc_ch4_valid_out <= mon_in_pwm(ctrl_reg[bsdvs_pkg::CTRL_MONSEL_LSB +: 3],
				pwm_mode_in);
		end
	end

	assign sink_limit_enable_out = ctrl_reg[bsdvs_pkg::CTRL_SINK_BIT];
	assign load_current_monitor_select_out = ctrl_reg[bsdvs_pkg::CTRL_MONSEL_LSB +: 3];
	assign dual_phase_out = dual_reg;
	assign voltage_code_out = {cur_code_reg[4], cur_code_reg[3], cur_code_reg[2],
		cur_code_reg[1], cur_code_reg[0]};

	a_short_hold_off: assert property (@(posedge mclk_in) disable iff (rst_in)
		buck_flag_reg[0] |=> buck_off_out[0]) else $error("short flag without rail off");
	a_qual_time_min: assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(buck_flag_reg[0]) |-> $past(qual_cnt_reg[0]) == 12'(QUAL_LAST))
		else $error("short latched before qualification");
	a_startup_masks: assert property (@(posedge mclk_in) disable iff (rst_in)
		startup_masked_reg |=> !$rose(linear_flag_reg[0])) else $error("latch during startup");
	a_read_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
		(accept && read_in && addr_snap_reg == bsdvs_pkg::OFS_BUCK_SHORT && short_set[4:0] == 5'h00)
		|=> (buck_flag_reg & $past(rd_snap_reg[4:0])) == 5'h00) else $error("read did not clear");
	a_thermal_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
		!ctrl_reg[bsdvs_pkg::CTRL_THERM_BIT] |=> buck_thermal_flags_out == 3'h0)
		else $error("thermal flag while disabled");
	a_pg_load_fail: assert property (@(posedge mclk_in) disable iff (rst_in)
		(!eff_mask[0] && !load_current_ok_in[0]) |=> !power_good_out)
		else $error("power good with overloaded source");
	a_irq_masked: assert property (@(posedge mclk_in) disable iff (rst_in)
		ctrl_reg[bsdvs_pkg::CTRL_IRQMASK_BIT] |=> !short_irq_out) else $error("masked irq raised");
	a_alt_zero_off: assert property (@(posedge mclk_in) disable iff (rst_in)
		|alt_off |=> (buck_off_out & $past(alt_off)) == $past(alt_off))
		else $error("alternate zero left rail on");
	a_slew_pace: assert property (@(posedge mclk_in) disable iff (rst_in)
		$changed(cur_code_reg[0]) |-> $past(step_cnt_reg[0]) == 7'(STEP_LAST))
		else $error("dvs code stepped early");
	a_bus_answer: assert property (@(posedge mclk_in) disable iff (rst_in)
		(req && waitrequest_out) |=> !waitrequest_out) else $error("no answer after one wait");

	c_short_latch: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(buck_flag_reg[0]));
	c_ramp_done: cover property (@(posedge mclk_in) disable iff (rst_in) $fell(ramping[0]));
	c_pg_high: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(power_good_out));
endmodule : bsdvs_top

/* shared/bsdvs_pkg.sv */
// Purpose: constants, register map and carrier types for buck supervision and DVS control
// Assumes: 20 MHz mclk_in, Avalon-MM register window of 32-bit words
// Notes:   short status registers clear on read
package bsdvs_pkg;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int NUM_BUCK        = 5;
	localparam int NUM_LINEAR      = 5;
	localparam int NUM_DVS         = 3;
	// short qualification, least time rounds up
	localparam int QUAL_TIME_NS    = 155000;
	localparam int QUAL_CYCLES     = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// startup shutdown mask
	localparam int STARTUP_TIME_NS = 2000000;
	localparam int STARTUP_CYCLES  = STARTUP_TIME_NS / CLK_PERIOD_NS;
	// dvs slew: one 10 mV code step at 2.5 mV/us
	localparam int SLEW_UV_PER_US  = 2500;
	localparam int VSTEP_UV        = 10000;
	localparam int STEP_TIME_NS    = VSTEP_UV * 1000 / SLEW_UV_PER_US;
	localparam int STEP_CYCLES     = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL         = 8'h00;
	localparam logic [7:0] OFS_MASK_A       = 8'h04;
	localparam logic [7:0] OFS_MASK_B       = 8'h08;
	localparam logic [7:0] OFS_STATUS       = 8'h0C;
	localparam logic [7:0] OFS_BUCK_SHORT   = 8'h10;
	localparam logic [7:0] OFS_LINEAR_SHORT = 8'h14;
	localparam logic [7:0] OFS_RAIL_BASE    = 8'h20;
	localparam logic [7:0] OFS_RAIL_LAST    = 8'h30;
	// control register fields
	localparam int CTRL_SINK_BIT    = 0;
	localparam int CTRL_THERM_BIT   = 1;
	localparam int CTRL_CMPINC_BIT  = 2;
	localparam int CTRL_IRQMASK_BIT = 3;
	localparam int CTRL_MONSEL_LSB  = 4;
	localparam int CTRL_PHASE_LSB   = 8;
	localparam logic [9:0] CTRL_RESET   = 10'h003;
	localparam logic [4:0] MASK_A_RESET = 5'h1E;
	localparam logic       MASK_B_RESET = 1'b0;
	// status register and rail code fields
	localparam int STAT_PG_BIT      = 8;
	localparam int STAT_DUAL_BIT    = 9;
	localparam int STAT_SMASK_BIT   = 10;
	localparam int RAIL_CODE_LSB    = 24;
	// monitor select codes
	localparam logic [2:0] MON_NONE = 3'h0;
	localparam logic [2:0] MON_B1   = 3'h1;
	localparam logic [2:0] MON_B2   = 3'h2;
	localparam logic [2:0] MON_B12  = 3'h3;
	localparam logic [2:0] MON_B3   = 3'h4;
	localparam logic [2:0] MON_B5   = 3'h5;
	// phase force codes
	localparam logic [1:0] PHASE_FORCE_DUAL   = 2'h1;
	localparam logic [1:0] PHASE_FORCE_SINGLE = 2'h2;
	// avalon response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [2:0] pin_map;
		logic       roof_floor_en;
		logic       cmd;
		logic [7:0] alternate_voltage_setting;
		logic [7:0] primary_voltage_setting;
	} bsdvs_rail_cfg_t;

	localparam bsdvs_rail_cfg_t RAIL_CFG_RESET = 21'h000000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bsdvs_bus_state_t;
endpackage : bsdvs_pkg

/* tb/bsdvs_rail_model.sv */
// Purpose: rail side model, overcurrent while a shorted rail is on
// Assumes: short requests come from the bench
// Notes:   a rail switched off by the device draws nothing
`timescale 1ns/1ns
module bsdvs_rail_model (
	// short requests and rail state
	input  wire logic [9:0] short_req_in,
	input  wire logic [9:0] rail_enable_in,
	// shutdown from the device
	input  wire logic [4:0] buck_off_in,
	input  wire logic [4:0] linear_off_in,
	// sensed overcurrent
	output logic      [9:0] overcurrent_out
);
	assign overcurrent_out = short_req_in & rail_enable_in & ~{linear_off_in, buck_off_in};
endmodule : bsdvs_rail_model

/* tb/bsdvs_top_bench.sv */
// Purpose: register-level bench for buck supervision and dvs control
// Assumes: short startup mask of 50 cycles
// Notes:   short timing bracketed by the qualification window
`timescale 1ns/1ns
module bsdvs_top_bench;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [7:0]  address_in = 8'h00;
	logic        read_in = 1'b0;
	logic        write_in = 1'b0;
	logic [31:0] writedata_in = 32'h0;
	logic [9:0]  rails = 10'h000;
	logic [9:0]  short_req = 10'h000;
	logic [9:0]  overcurrent;
	logic [4:0]  volt_ok = 5'h00;
	logic [4:0]  load_ok = 5'h00;
	logic [2:0]  therm = 3'h0;
	logic [4:0]  pwm = 5'h00;
	logic [2:0]  pins = 3'h0;
	logic        adc_ok = 1'b0;
	logic [31:0] readdata_out;
	logic        waitrequest_out;
	logic [1:0]  response_out;
	logic        sink_limit_enable_out;
	logic        adc_ch4_valid_out;
	logic [2:0]  buck_thermal_flags_out;
	logic        short_irq_out;
	logic [4:0]  buck_off_out;
	logic [4:0]  linear_off_out;
	logic        power_good_out;
	logic [39:0] voltage_code_out;
	logic [31:0] rd;
	logic [1:0]  resp;
	wire  [31:0] off = {22'h0, linear_off_out, buck_off_out};
	int          err_count = 0;
	int          total_checks = 0;

	always #25 mclk_in = ~mclk_in;

	bsdvs_top #(.STARTUP_CYCLES(50)) u_bsdvs_top (.mclk_in(mclk_in), .rst_in(rst_in),
		.address_in(address_in), .read_in(read_in), .write_in(write_in),
		.writedata_in(writedata_in), .byteenable_in(4'hF), .readdata_out(readdata_out),
		.waitrequest_out(waitrequest_out), .response_out(response_out),
		.device_enable_in(1'b1), .rail_enable_in(rails), .overcurrent_in(overcurrent),
		.voltage_ok_in(volt_ok), .load_current_ok_in(load_ok), .adc_current_ok_in(adc_ok),
		.thermal_sensor_in(therm), .pwm_mode_in(pwm), .light_load_in(1'b0),
		.otp_dual_phase_in(1'b0), .sleep_request_pin_in(pins[0]),
		.rail_control_pin_a_in(pins[1]), .rail_control_pin_b_in(pins[2]),
		.sink_limit_enable_out(sink_limit_enable_out), .load_current_monitor_select_out(),
		.adc_ch4_valid_out(adc_ch4_valid_out), .buck_thermal_flags_out(buck_thermal_flags_out),
		.short_irq_out(short_irq_out), .buck_off_out(buck_off_out),
		.linear_off_out(linear_off_out), .power_good_out(power_good_out),
		.voltage_code_out(voltage_code_out), .dual_phase_out(), .two_phase_active_out());

	bsdvs_rail_model u_bsdvs_rail_model (.short_req_in(short_req), .rail_enable_in(rails),
		.buck_off_in(buck_off_out), .linear_off_in(linear_off_out),
		.overcurrent_out(overcurrent));

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : cyc

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask : chk

	// request held until waitrequest sampled low
	task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk_in);
		read_in <= ~wr;
		write_in <= wr;
		address_in <= adr;
		writedata_in <= wd;
		do
		begin
			@(posedge mclk_in);
			n++;
		end
		while (waitrequest_out !== 1'b0 && n < 50);
		rd = readdata_out;
		resp = response_out;
		if (n >= 50)
			chk("waitrequest", 32'h0, 32'h1);
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask : bus

	task automatic short_case(input int idx, input logic [7:0] ofs, input logic irq);
		short_req[idx] <= 1'b1;
		cyc(3000);
		short_req[idx] <= 1'b0;
		cyc(4);
		chk("glitch off", 32'h0, off);
		short_req[idx] <= 1'b1;
		cyc(3090);
		chk("early off", 32'h0, off);
		cyc(620);
		chk("late off", 32'h1 << idx, off);
		short_req[idx] <= 1'b0;
		cyc(20);
		chk("held off", 32'h1 << idx, off);
		chk("irq", {31'h0, irq}, {31'h0, short_irq_out});
		bus(1'b0, ofs, 32'h0);
		chk("flags", 32'h1 << (idx % 5), rd);
		cyc(3);
		chk("off cleared", 32'h0, off);
		bus(1'b0, ofs, 32'h0);
		chk("flags cleared", 32'h0, rd);
	endtask : short_case

	initial
	begin
		cyc(40000);
		$display("watchdog expired");
		err_count++;
		stop_test();
	end

	initial
	begin
		cyc(16);
		rst_in <= 1'b0;
		cyc(2);
		chk("sink out", 32'h1, {31'h0, sink_limit_enable_out});
		bus(1'b0, bsdvs_pkg::OFS_CTRL, 32'h0);
		chk("ctrl reset", 32'h003, rd);
		bus(1'b0, bsdvs_pkg::OFS_MASK_A, 32'h0);
		chk("mask reset", 32'h1E, rd);
		bus(1'b0, 8'hFC, 32'h0);
		chk("unmapped", {30'h0, bsdvs_pkg::RESP_SLVERR}, {30'h0, resp});
		therm <= 3'h7;
		rails <= 10'h3FF;
		cyc(100);
		chk("thermal on", 32'h7, {29'h0, buck_thermal_flags_out});
		short_case(0, bsdvs_pkg::OFS_BUCK_SHORT, 1'b1);
		bus(1'b1, bsdvs_pkg::OFS_CTRL, 32'h018);
		cyc(3);
		chk("sink off", 32'h0, {31'h0, sink_limit_enable_out});
		chk("thermal off", 32'h0, {29'h0, buck_thermal_flags_out});
		short_case(5, bsdvs_pkg::OFS_LINEAR_SHORT, 1'b0);
		pwm <= 5'h01;
		cyc(5);
		chk("adc valid", 32'h1, {31'h0, adc_ch4_valid_out});
		pwm <= 5'h00;
		volt_ok <= 5'h01;
		load_ok <= 5'h01;
		cyc(5);
		chk("adc idle", 32'h0, {31'h0, adc_ch4_valid_out});
		chk("pg both", 32'h1, {31'h0, power_good_out});
		volt_ok <= 5'h00;
		cyc(5);
		chk("pg volt", 32'h0, {31'h0, power_good_out});
		bus(1'b1, bsdvs_pkg::OFS_MASK_B, 32'h1);
		cyc(5);
		chk("pg type", 32'h1, {31'h0, power_good_out});
		bus(1'b1, bsdvs_pkg::OFS_CTRL, 32'h01C);
		cyc(5);
		chk("pg adc low", 32'h0, {31'h0, power_good_out});
		adc_ok <= 1'b1;
		cyc(5);
		chk("pg adc high", 32'h1, {31'h0, power_good_out});
		load_ok <= 5'h00;
		cyc(5);
		chk("pg load", 32'h0, {31'h0, power_good_out});
		bus(1'b1, 8'h2C, 32'h0006_2040);
		cyc(10);
		chk("pin low", 32'h20, {24'h0, voltage_code_out[31:24]});
		pins <= 3'h1;
		cyc(10);
		chk("pin high", 32'h40, {24'h0, voltage_code_out[31:24]});
		bus(1'b1, 8'h2C, 32'h0001_2040);
		cyc(5);
		chk("cmd alt", 32'h20, {24'h0, voltage_code_out[31:24]});
		bus(1'b1, 8'h2C, 32'h0000_2040);
		cyc(5);
		chk("cmd pri", 32'h40, {24'h0, voltage_code_out[31:24]});
		bus(1'b1, 8'h24, 32'h0001_0040);
		cyc(5);
		chk("alt zero", 32'h2, off);
		bus(1'b1, bsdvs_pkg::OFS_MASK_B, 32'h0);
		load_ok <= 5'h01;
		bus(1'b1, 8'h20, 32'h0000_0002);
		cyc(bsdvs_pkg::STEP_CYCLES / 2);
		chk("ramp start", 32'h0, {24'h0, voltage_code_out[7:0]});
		chk("pg ramp", 32'h1, {31'h0, power_good_out});
		cyc(bsdvs_pkg::STEP_CYCLES);
		chk("ramp mid", 32'h1, {24'h0, voltage_code_out[7:0]});
		cyc(2 * bsdvs_pkg::STEP_CYCLES);
		chk("ramp end", 32'h2, {24'h0, voltage_code_out[7:0]});
		chk("pg settled", 32'h0, {31'h0, power_good_out});
		stop_test();
	end
endmodule : bsdvs_top_bench
